// ===== iep_defines.vh
// constants for the interrupt enable and priority block
`ifndef IEP_DEFINES_VH
`define IEP_DEFINES_VH

// register addresses on the special function register port
`define IEP_ADDR_EN_MAIN      8'hA8
`define IEP_ADDR_LVL_HI_MAIN  8'hB7
`define IEP_ADDR_LVL_LO_MAIN  8'hB8
`define IEP_ADDR_EN_EXT       8'hE8
`define IEP_ADDR_LVL_HI_EXT   8'hF7
`define IEP_ADDR_LVL_LO_EXT   8'hFF

// reset values
`define IEP_RST_EN_MAIN       8'h00
`define IEP_RST_EN_EXT        8'h00
`define IEP_RST_LVL           8'h00

// implemented bits; reserved positions read zero and ignore writes
`define IEP_MASK_MAIN         8'hFF
`define IEP_MASK_EN_EXT       8'hF7
`define IEP_MASK_LVL_EXT      8'hF3

// field positions in the main enable and main level registers
`define IEP_BIT_GLOBAL        7
`define IEP_BIT_ADC           6
`define IEP_BIT_BROWNOUT      5
`define IEP_BIT_UART          4
`define IEP_BIT_TIMER1        3
`define IEP_BIT_EXT1          2
`define IEP_BIT_TIMER0        1
`define IEP_BIT_EXT0          0
`define IEP_BIT_CAP_LVL       7

// field positions in the extended enable and extended level registers
`define IEP_BIT_TIMER2        7
`define IEP_BIT_SPI           6
`define IEP_BIT_PWM           5
`define IEP_BIT_WDOG          4
`define IEP_BIT_CAP_EN        2
`define IEP_BIT_KEYPAD        1
`define IEP_BIT_I2C           0

// source count and arbitration ranks, 0 is served first
`define IEP_NUM_SRC           14
`define IEP_RANK_EXT0         0
`define IEP_RANK_BROWNOUT     1
`define IEP_RANK_WDOG         2
`define IEP_RANK_TIMER0       3
`define IEP_RANK_I2C          4
`define IEP_RANK_ADC          5
`define IEP_RANK_EXT1         6
`define IEP_RANK_KEYPAD       7
`define IEP_RANK_TIMER1       8
`define IEP_RANK_UART         9
`define IEP_RANK_PWM          10
`define IEP_RANK_SPI          11
`define IEP_RANK_TIMER2       12
`define IEP_RANK_CAPTURE      13

// number of priority levels
`define IEP_NUM_LVL           4

`endif

// ===== iep_arbiter.v
// level and rank arbiter picking the winning pending source
`timescale 1ns/1ps
`default_nettype none

module iep_arbiter #(
    parameter NSRC = 14
) (
    input  wire [NSRC-1:0]   pend,
    input  wire [2*NSRC-1:0] lvl,
    output reg               found,
    output reg  [3:0]        win_idx,
    output reg  [1:0]        win_lvl
);

    integer i;

    // scan in rank order; strictly greater level replaces the winner,
    // so among equal levels the lower rank index keeps the win
    always @* begin
        found   = 1'b0;
        win_idx = 4'h0;
        win_lvl = 2'h0;
        for (i = 0; i < NSRC; i = i + 1) begin
            if (pend[i] && (!found || lvl[2*i +: 2] > win_lvl)) begin
                found   = 1'b1;
                win_idx = i[3:0];
                win_lvl = lvl[2*i +: 2];
            end
        end
    end

endmodule

`default_nettype wire

// ===== iep_top.v
// interrupt enable, four-level priority and in-service tracking
`timescale 1ns/1ps
`default_nettype none
`include "iep_defines.vh"

// Functional notes
// - global gate bit 7 of main enable blocks all; else per-source enables apply
// - uart enable passes either transmit-done or receive-done flag, blocks both
// - timer 1 enable at main enable bit 3 gates timer 1 overflow
// - timer 0 enable at main enable bit 1 gates timer 0 overflow
// - main enable bit 2 gates external pin 1, bit 0 external pin 0
// - adc enable at bit 6, brownout enable at bit 5 of main enable
// - main enable register resets to all zeros
// - extended enable holds timer 2 bit 7, spi bit 6, pwm brake bit 5
// - extended enable: watchdog 4, capture 2, keypad 1, i2c 0; bit 3 reserved
// - level is high-register bit over low-register bit at same position
// - main low level bits 7..0: capture adc brownout uart t1 ext1 t0 ext0
// - main high level register uses the same order, resets to zero
// - extended low level: t2 spi pwm watchdog, 3:2 reserved, keypad i2c
// - extended high level mirrors extended low level layout, resets zero
// - pair 00 is level 0 lowest up to 11 level 3 highest
// - only a strictly higher level preempts; level 3 is never preempted
// - equal levels resolve by fixed rank, external 0 first, capture last
// - only return-from-service ends the in-service state of a level
module iep_top #(
    parameter NSRC = `IEP_NUM_SRC
) (
    input  wire       ref_clk,
    input  wire       sys_rst,
    input  wire [7:0] sfr_addr,
    input  wire       sfr_wr_en,
    input  wire [7:0] sfr_wdata,
    output wire [7:0] sfr_rdata,
    input  wire       ext_irq_pin_zero,
    input  wire       ext_irq_pin_one,
    input  wire       brownout_detector,
    input  wire       watchdog_flag,
    input  wire       timer0_overflow_flag,
    input  wire       timer1_overflow_flag,
    input  wire       timer2_flag,
    input  wire       i2c_flag,
    input  wire       adc_flag,
    input  wire       keypad_flag,
    input  wire       uart_tx_done_flag,
    input  wire       uart_rx_done_flag,
    input  wire       pwm_brake_flag,
    input  wire       spi_flag,
    input  wire       capture_flag,
    input  wire       cpu_irq_ack,
    input  wire       return_from_service,
    output wire       irq_req,
    output wire [3:0] irq_src,
    output wire [1:0] irq_level,
    output wire [3:0] in_service
);

    ////////////////////////////////////////////////////////////////////
    // registers

    reg [7:0] en_main_q;
    reg [7:0] en_ext_q;
    reg [7:0] lvl_hi_main_q;
    reg [7:0] lvl_lo_main_q;
    reg [7:0] lvl_hi_ext_q;
    reg [7:0] lvl_lo_ext_q;
    reg [7:0] rdata_q;
    reg [7:0] rdata_d;
    reg       irq_req_q;
    reg [3:0] irq_src_q;
    reg [1:0] irq_level_q;
    reg [3:0] in_svc_q;
    reg [3:0] in_svc_d;

    wire [NSRC-1:0]   flag_vec;
    wire [NSRC-1:0]   en_vec;
    wire [NSRC-1:0]   lo_vec;
    wire [NSRC-1:0]   hi_vec;
    wire [NSRC-1:0]   pend;
    wire [2*NSRC-1:0] lvl_flat;
    wire              found;
    wire [3:0]        win_idx;
    wire [1:0]        win_lvl;
    wire              global_irq_gate;
    wire              svc_any;
    wire [1:0]        svc_top;
    wire [2:0]        svc_code;
    wire              may_preempt;

    ////////////////////////////////////////////////////////////////////
    // functions

    // reorder a main/extended register pair into rank order; the
    // capture bit sits in the extended enable but in the main level
    // registers, so the caller says which one it comes from
    function [13:0] rank_vec;
        input [7:0] m;
        input [7:0] x;
        input       cap_ext;
        begin
            rank_vec                     = 14'h0000;
            rank_vec[`IEP_RANK_EXT0]     = m[`IEP_BIT_EXT0];
            rank_vec[`IEP_RANK_BROWNOUT] = m[`IEP_BIT_BROWNOUT];
            rank_vec[`IEP_RANK_WDOG]     = x[`IEP_BIT_WDOG];
            rank_vec[`IEP_RANK_TIMER0]   = m[`IEP_BIT_TIMER0];
            rank_vec[`IEP_RANK_I2C]      = x[`IEP_BIT_I2C];
            rank_vec[`IEP_RANK_ADC]      = m[`IEP_BIT_ADC];
            rank_vec[`IEP_RANK_EXT1]     = m[`IEP_BIT_EXT1];
            rank_vec[`IEP_RANK_KEYPAD]   = x[`IEP_BIT_KEYPAD];
            rank_vec[`IEP_RANK_TIMER1]   = m[`IEP_BIT_TIMER1];
            rank_vec[`IEP_RANK_UART]     = m[`IEP_BIT_UART];
            rank_vec[`IEP_RANK_PWM]      = x[`IEP_BIT_PWM];
            rank_vec[`IEP_RANK_SPI]      = x[`IEP_BIT_SPI];
            rank_vec[`IEP_RANK_TIMER2]   = x[`IEP_BIT_TIMER2];
            if (cap_ext) begin
                rank_vec[`IEP_RANK_CAPTURE] = x[`IEP_BIT_CAP_EN];
            end else begin
                rank_vec[`IEP_RANK_CAPTURE] = m[`IEP_BIT_CAP_LVL];
            end
        end
    endfunction

    // highest level currently in service, bit 2 says any is active
    function [2:0] top_level;
        input [3:0] svc;
        begin
            if (svc[3]) begin
                top_level = 3'h7;
            end else if (svc[2]) begin
                top_level = 3'h6;
            end else if (svc[1]) begin
                top_level = 3'h5;
            end else if (svc[0]) begin
                top_level = 3'h4;
            end else begin
                top_level = 3'h0;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // register writes

    // reserved positions are masked so they never store a one
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            en_main_q     <= `IEP_RST_EN_MAIN;
            en_ext_q      <= `IEP_RST_EN_EXT;
            lvl_hi_main_q <= `IEP_RST_LVL;
            lvl_lo_main_q <= `IEP_RST_LVL;
            lvl_hi_ext_q  <= `IEP_RST_LVL;
            lvl_lo_ext_q  <= `IEP_RST_LVL;
        end else if (sfr_wr_en) begin
            case (sfr_addr)
                `IEP_ADDR_EN_MAIN: begin
                    en_main_q <= sfr_wdata & `IEP_MASK_MAIN;
                end
                `IEP_ADDR_EN_EXT: begin
                    en_ext_q <= sfr_wdata & `IEP_MASK_EN_EXT;
                end
                `IEP_ADDR_LVL_HI_MAIN: begin
                    lvl_hi_main_q <= sfr_wdata & `IEP_MASK_MAIN;
                end
                `IEP_ADDR_LVL_LO_MAIN: begin
                    lvl_lo_main_q <= sfr_wdata & `IEP_MASK_MAIN;
                end
                `IEP_ADDR_LVL_HI_EXT: begin
                    lvl_hi_ext_q <= sfr_wdata & `IEP_MASK_LVL_EXT;
                end
                `IEP_ADDR_LVL_LO_EXT: begin
                    lvl_lo_ext_q <= sfr_wdata & `IEP_MASK_LVL_EXT;
                end
                default: begin
                    en_main_q <= en_main_q;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register reads

    // read data is registered, so it follows the address by one edge;
    // unmapped addresses answer zero so other blocks can be or-ed in
    always @* begin
        case (sfr_addr)
            `IEP_ADDR_EN_MAIN:     rdata_d = en_main_q;
            `IEP_ADDR_EN_EXT:      rdata_d = en_ext_q;
            `IEP_ADDR_LVL_HI_MAIN: rdata_d = lvl_hi_main_q;
            `IEP_ADDR_LVL_LO_MAIN: rdata_d = lvl_lo_main_q;
            `IEP_ADDR_LVL_HI_EXT:  rdata_d = lvl_hi_ext_q;
            `IEP_ADDR_LVL_LO_EXT:  rdata_d = lvl_lo_ext_q;
            default:               rdata_d = 8'h00;
        endcase
    end

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // source gating and level forming

    assign global_irq_gate = en_main_q[`IEP_BIT_GLOBAL];

    // uart raises one request for either flag; the single enable
    // below therefore passes or blocks both causes together
    assign flag_vec[`IEP_RANK_EXT0]     = ext_irq_pin_zero;
    assign flag_vec[`IEP_RANK_BROWNOUT] = brownout_detector;
    assign flag_vec[`IEP_RANK_WDOG]     = watchdog_flag;
    assign flag_vec[`IEP_RANK_TIMER0]   = timer0_overflow_flag;
    assign flag_vec[`IEP_RANK_I2C]      = i2c_flag;
    assign flag_vec[`IEP_RANK_ADC]      = adc_flag;
    assign flag_vec[`IEP_RANK_EXT1]     = ext_irq_pin_one;
    assign flag_vec[`IEP_RANK_KEYPAD]   = keypad_flag;
    assign flag_vec[`IEP_RANK_TIMER1]   = timer1_overflow_flag;
    assign flag_vec[`IEP_RANK_UART]     =
        uart_tx_done_flag | uart_rx_done_flag;
    assign flag_vec[`IEP_RANK_PWM]      = pwm_brake_flag;
    assign flag_vec[`IEP_RANK_SPI]      = spi_flag;
    assign flag_vec[`IEP_RANK_TIMER2]   = timer2_flag;
    assign flag_vec[`IEP_RANK_CAPTURE]  = capture_flag;

    // enable bits by position
    assign en_vec = rank_vec(en_main_q, en_ext_q, 1'b1);
    // level bits share one layout per register pair
    assign lo_vec = rank_vec(lvl_lo_main_q, lvl_lo_ext_q, 1'b0);
    assign hi_vec = rank_vec(lvl_hi_main_q, lvl_hi_ext_q, 1'b0);

    // per source: gate the flag and pack the level pair
    genvar g;
    generate
        for (g = 0; g < NSRC; g = g + 1) begin : g_src
            assign pend[g] = flag_vec[g] & en_vec[g]
                           & global_irq_gate;
            // high bit over low bit, 00 lowest to 11 highest
            assign lvl_flat[2*g +: 2] = {hi_vec[g], lo_vec[g]};
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // arbitration

    // highest level wins, ties by rank order of the index
    iep_arbiter #(
        .NSRC    (NSRC)
    ) u_arb (
        .pend    (pend),
        .lvl     (lvl_flat),
        .found   (found),
        .win_idx (win_idx),
        .win_lvl (win_lvl)
    );

    // decode once; bit 2 flags any service, the low pair is its level
    assign svc_code = top_level(in_svc_q);
    assign svc_any  = svc_code[2];
    assign svc_top  = svc_code[1:0];

    // a level-3 service can never be beaten since nothing exceeds it
    assign may_preempt = found && (!svc_any || win_lvl > svc_top);

    ////////////////////////////////////////////////////////////////////
    // request to the core

    // the request is re-evaluated every cycle, so a lower source that
    // is overtaken simply yields; an ack itself takes the request down at
    // its edge, and the in-service mark keeps it down on later evaluations
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_req_q   <= 1'b0;
            irq_src_q   <= 4'h0;
            irq_level_q <= 2'h0;
        end else if (cpu_irq_ack) begin
            irq_req_q   <= 1'b0; // avoid a second call on the same grant
            irq_src_q   <= irq_src_q;
            irq_level_q <= irq_level_q;
        end else begin
            irq_req_q   <= may_preempt;
            irq_src_q   <= win_idx;
            irq_level_q <= win_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // in-service levels

    // a plain return does not reach this block at all, so the level
    // stays marked until the core reports a return-from-service
    always @* begin
        in_svc_d = in_svc_q;
        if (return_from_service && svc_any) begin
            in_svc_d[svc_top] = 1'b0;
        end
        if (cpu_irq_ack && irq_req_q) begin
            in_svc_d[irq_level_q] = 1'b1;
        end
    end

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            in_svc_q <= 4'h0;
        end else begin
            in_svc_q <= in_svc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign sfr_rdata  = rdata_q;
    assign irq_req    = irq_req_q;
    assign irq_src    = irq_src_q;
    assign irq_level  = irq_level_q;
    assign in_service = in_svc_q;

endmodule

`default_nettype wire

// ===== iep_top_properties.sv
// port-level assertions for the interrupt enable and priority block
`timescale 1ns/1ps
`default_nettype none
module iep_top_chk (
    input wire logic       ref_clk,
    input wire logic       sys_rst,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr_en,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic       cpu_irq_ack,
    input wire logic       return_from_service,
    input wire logic       irq_req,
    input wire logic [1:0] irq_level,
    input wire logic [3:0] in_service
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic [7:0] en_main_q;
    logic [1:0] top_lvl;
    logic       taken;
    // shadow of the main enable register, rebuilt from the write port
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            en_main_q <= 8'h00;
        end else if (sfr_wr_en && sfr_addr == 8'hA8) begin
            en_main_q <= sfr_wdata;
        end
    end
    // highest level in service; reads 0 when idle, so guard its users
    always_comb begin
        top_lvl = 2'h0;
        for (int i = 0; i < 4; i++) begin
            if (in_service[i]) begin
                top_lvl = i[1:0];
            end
        end
    end
    assign taken = cpu_irq_ack && irq_req;
    ////////////////////////////////////////////////////////////////////
    a_unmapped_reads_zero: assert property (
        !(sfr_addr inside {8'hA8, 8'hB7, 8'hB8, 8'hE8, 8'hF7, 8'hFF})
        |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
    a_main_en_read: assert property (
        sfr_addr == 8'hA8 |=> sfr_rdata == $past(en_main_q))
        else $error("main enable readback wrong");
    a_ext_reserved_zero: assert property (
        sfr_addr == 8'hE8 |=> !sfr_rdata[3]) else $error("enable bit 3 set");
    a_lvl_reserved_zero: assert property (
        sfr_addr inside {8'hF7, 8'hFF} |=> sfr_rdata[3:2] == 2'b00)
        else $error("level bits 3:2 set");
    a_gate_blocks_all: assert property (
        !en_main_q[7] |=> !irq_req) else $error("request with gate off");
    a_ack_drops_req: assert property (
        taken |=> !irq_req) else $error("request held after ack");
    a_ack_marks_level: assert property (
        taken && !return_from_service |=> in_service ==
        ($past(in_service) | (4'h1 << $past(irq_level))))
        else $error("ack did not mark level");
    a_top_level_locks: assert property (
        in_service[3] |=> !irq_req) else $error("level 3 preempted");
    a_req_above_svc: assert property (
        irq_req && in_service != 4'h0 |-> irq_level > top_lvl)
        else $error("request not above service level");
    a_ret_clears_top: assert property (
        return_from_service && !taken && in_service != 4'h0 |=> in_service
        == ($past(in_service) & ~(4'h1 << $past(top_lvl))))
        else $error("return cleared wrong level");
    a_svc_holds: assert property (
        !return_from_service && !taken |=> $stable(in_service))
        else $error("service state changed alone");
    c_ack_taken: cover property (taken);
    c_preempt: cover property (taken && in_service != 4'h0);
    c_return: cover property (return_from_service && in_service != 4'h0);
endmodule

bind iep_top iep_top_chk u_chk (
    .ref_clk, .sys_rst, .sfr_addr, .sfr_wr_en, .sfr_wdata, .sfr_rdata,
    .cpu_irq_ack, .return_from_service, .irq_req, .irq_level, .in_service
);
`default_nettype wire

// ===== iep_far_model.sv
// peripheral flag sources and a core that takes and returns from calls
`timescale 1ns/1ps
`default_nettype none
module iep_far_model (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic [14:0] flag_cmd,
    input  wire logic        ack_en,
    input  wire logic [3:0]  ack_wait,
    input  wire logic        ret_cmd,
    input  wire logic        irq_req,
    output logic      [14:0] flags,
    output logic             cpu_irq_ack,
    output logic             return_from_service
);
    logic [3:0] wait_q;
    // core acks only a standing request, after ack_wait idle cycles
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flags <= 15'h0000;
            cpu_irq_ack <= 1'b0;
            return_from_service <= 1'b0;
            wait_q <= 4'h0;
        end else begin
            flags <= flag_cmd;
            return_from_service <= ret_cmd;
            cpu_irq_ack <= 1'b0;
            if (cpu_irq_ack || !irq_req || !ack_en) begin
                wait_q <= 4'h0;
            end else if (wait_q == ack_wait) begin
                cpu_irq_ack <= 1'b1;
            end else begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== iep_top_tb.sv
// self-checking bench for the interrupt enable and priority block
`timescale 1ns/1ps
`default_nettype none
module iep_top_tb;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  sfr_addr = 8'h00;
    logic        sfr_wr_en = 1'b0;
    logic [7:0]  sfr_wdata = 8'h00;
    logic [14:0] flag_cmd = 15'h0000;
    logic        ack_en = 1'b0;
    logic [3:0]  ack_wait = 4'h0;
    logic        ret_cmd = 1'b0;
    wire  [14:0] fl;
    wire  [7:0]  sfr_rdata;
    wire  [3:0]  irq_src;
    wire  [1:0]  irq_level;
    wire  [3:0]  in_service;
    wire         irq_req, cpu_irq_ack, return_from_service;
    int          num_errors = 0;
    int          checks_done = 0;
    int          r;
    // per rank: enable bit and whether it lives in the extended register
    int          eb [14] = '{0, 5, 4, 1, 0, 6, 2, 1, 3, 4, 5, 6, 7, 2};
    logic [13:0] on_ext = 14'h3C94;
    logic [7:0]  ra [6] = '{8'hA8, 8'hB7, 8'hB8, 8'hE8, 8'hF7, 8'hFF};
    logic [7:0]  rm [6] = '{8'hFF, 8'hFF, 8'hFF, 8'hF7, 8'hF3, 8'hF3};

    always #12.5 ref_clk = ~ref_clk;

    iep_top dut (
        .ref_clk, .sys_rst, .sfr_addr, .sfr_wr_en, .sfr_wdata, .sfr_rdata,
        .ext_irq_pin_zero(fl[0]), .brownout_detector(fl[1]),
        .watchdog_flag(fl[2]), .timer0_overflow_flag(fl[3]),
        .i2c_flag(fl[4]), .adc_flag(fl[5]), .ext_irq_pin_one(fl[6]),
        .keypad_flag(fl[7]), .timer1_overflow_flag(fl[8]),
        .uart_tx_done_flag(fl[9]), .pwm_brake_flag(fl[10]),
        .spi_flag(fl[11]), .timer2_flag(fl[12]), .capture_flag(fl[13]),
        .uart_rx_done_flag(fl[14]), .cpu_irq_ack, .return_from_service,
        .irq_req, .irq_src, .irq_level, .in_service
    );
    iep_far_model far (
        .ref_clk, .sys_rst, .flag_cmd, .ack_en, .ack_wait, .ret_cmd,
        .irq_req, .flags(fl), .cpu_irq_ack, .return_from_service
    );
    ////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_wr_en <= 1'b1;
        sfr_wdata <= d;
        @(posedge ref_clk);
        sfr_wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        sfr_addr <= a;
        tick(1);
        chk(sfr_rdata, exp);
    endtask
    // bounded wait on in_service (sel=1) or irq_req; a timeout ends run
    task automatic wait_for(input logic sel, input logic [3:0] exp);
        tick(1); // never look in the time step of the launching edge
        for (int n = 0; n < 40 &&
             (sel ? in_service : {3'h0, irq_req}) !== exp; n++) tick(1);
        chk(sel ? in_service : {3'h0, irq_req}, exp);
        if ((sel ? in_service : {3'h0, irq_req}) !== exp) conclude();
    endtask
    // enable one source at level lv, global gate bit 7 as given, all other enables and levels clear
    task automatic set_src(input int s, input logic gate,
                           input logic [1:0] lv);
        logic [7:0] v [6];
        int         lb;
        foreach (v[i]) v[i] = 8'h00;
        v[0][7] = gate;
        lb = (s == 13) ? 7 : eb[s];
        if (on_ext[s]) v[3][eb[s]] = 1'b1;
        else v[0][eb[s]] = 1'b1;
        v[(on_ext[s] && s != 13) ? 4 : 1][lb] = lv[1];
        v[(on_ext[s] && s != 13) ? 5 : 2][lb] = lv[0];
        for (int i = 0; i < 6; i++) wr(ra[i], v[i]);
    endtask
    task automatic ret;
        @(posedge ref_clk);
        ret_cmd <= 1'b1;
        @(posedge ref_clk);
        ret_cmd <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 6; i++) rd(ra[i], 8'h00);
        for (int i = 0; i < 6; i++) wr(ra[i], 8'hFF);
        for (int i = 0; i < 6; i++) rd(ra[i], rm[i]);
        wr(8'hA9, 8'h5A);
        rd(8'hA9, 8'h00);
        // each source: gate closed, then open, then own enable cleared
        for (int k = 0; k < 15; k++) begin
            r = (k == 14) ? 9 : k;
            set_src(r, 1'b0, r[1:0]);
            @(posedge ref_clk);
            flag_cmd <= 15'h0001 << k;
            tick(4);
            chk(irq_req, 1'b0);
            set_src(r, 1'b1, r[1:0]);
            wait_for(1'b0, 4'h1);
            chk(irq_src, r[3:0]);
            chk(irq_level, r[1:0]);
            wr(8'hA8, 8'h80);
            wr(8'hE8, 8'h00);
            tick(3);
            chk(irq_req, 1'b0);
            @(posedge ref_clk);
            flag_cmd <= 15'h0000;
        end
        // equal level goes by rank; a higher level beats rank
        wr(8'hA8, 8'h81);
        wr(8'hE8, 8'h04);
        wr(8'hB8, 8'h00);
        @(posedge ref_clk);
        flag_cmd <= 15'h2001;
        wait_for(1'b0, 4'h1);
        chk(irq_src, 4'h0);
        wr(8'hB7, 8'h80);
        wr(8'hB8, 8'h80);
        tick(3);
        chk(irq_src, 4'hD);
        chk(irq_level, 2'h3);
        @(posedge ref_clk);
        ack_en <= 1'b1;
        wait_for(1'b1, 4'h8);
        tick(6);
        chk(irq_req, 1'b0);
        @(posedge ref_clk);
        flag_cmd <= 15'h0001;
        ack_wait <= 4'h3;
        ret();
        wait_for(1'b1, 4'h1);
        // a level 1 timer 0 request preempts level 0 service
        wr(8'hA8, 8'h83);
        wr(8'hB8, 8'h02);
        @(posedge ref_clk);
        flag_cmd <= 15'h0009;
        wait_for(1'b1, 4'h3);
        chk(irq_src, 4'h3);
        @(posedge ref_clk);
        ack_en <= 1'b0;
        ret();
        tick(4);
        chk(in_service, 4'h1);
        chk(irq_req, 1'b1);
        conclude();
    end
endmodule
`default_nettype wire
